// >>> bench/shp_host_model.sv
// host processor model: drives the sram-style pins one access at a time
// assumes pins are sampled on mclk rising edges by the port
`timescale 1ns/1ps
module shp_host_model (
  // clock
  input wire logic mclk,
  // host pins
  output logic chip_select_n,
  output logic read_strobe_n,
  output logic write_strobe_n,
  output logic [6:0] addr,
  output logic fifo_sel,
  output logic [15:0] data_in,
  input wire logic [15:0] data_out
);
  // ==========================================================
  // idle bus
  initial begin
    chip_select_n = 1'b1;
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    addr = 7'h00;
    fifo_sel = 1'b0;
    data_in = 16'h0000;
  end
  // ==========================================================
  // one access: held four edges, then released for an idle edge
  task automatic acc(input logic cs, input logic rd, input logic wr,
      input logic fs, input logic [6:0] a, input logic [15:0] d,
      output logic [15:0] q);
    @(posedge mclk);
    chip_select_n <= ~cs;
    read_strobe_n <= ~rd;
    write_strobe_n <= ~wr;
    fifo_sel <= fs;
    addr <= a;
    data_in <= d;
    repeat (4) @(posedge mclk);
    q = data_out;
    chip_select_n <= 1'b1;
    read_strobe_n <= 1'b1;
    write_strobe_n <= 1'b1;
    // released bus must not keep showing the written value
    data_in <= ~d;
    @(posedge mclk);
  endtask
endmodule

// >>> bench/tb.sv
// self-checking bench for the sram-style host port
// assumes the host model drives the pins and the bench the rest
`timescale 1ns/1ps
`define CHK(got, exp) begin \
  cmp_count++; \
  if ((got) !== (exp)) begin \
    failures++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); \
  end \
end
module tb;
  logic mclk, srst, chip_select_n, read_strobe_n, write_strobe_n;
  logic [6:0] addr, wr_addr, rd_addr, last_waddr, last_raddr;
  logic fifo_sel, data_oe, big_endian, sleep_req, wr_valid, rd_req;
  logic [15:0] data_in, data_out, q;
  logic [7:0] irq_src, irq_enable, irq_holdoff;
  logic irq_polarity_high, irq_open_drain, irq_out, irq_oe;
  logic [31:0] wr_word, rd_word, last_word;
  logic asleep, write_enabled, speed_strap, crossover_auto_enable;
  logic cable_reversed, manual_reverse, link_speed_100, link_duplex_full;
  logic link_autoneg, auto_crossover_on, pairs_swapped;
  int failures = 0;
  int cmp_count = 0;
  int wr_cnt = 0;
  int rd_cnt = 0;
  int oe_cnt = 0;
  // ==========================================================
  // design, host and internal-path monitor
  shp_host_port #(.SRC_W(8)) dut (.mclk, .srst, .chip_select_n,
    .read_strobe_n, .write_strobe_n, .addr, .fifo_sel, .data_in,
    .data_out, .data_oe, .big_endian, .irq_src, .irq_enable,
    .irq_polarity_high, .irq_open_drain, .irq_holdoff, .sleep_req,
    .wr_word, .wr_addr, .wr_valid, .rd_addr, .rd_req, .rd_word, .asleep,
    .write_enabled, .speed_strap, .crossover_auto_enable, .cable_reversed,
    .manual_reverse, .link_speed_100, .link_duplex_full, .link_autoneg,
    .auto_crossover_on, .pairs_swapped, .irq_out, .irq_oe);
  shp_host_model host (.mclk, .chip_select_n, .read_strobe_n,
    .write_strobe_n, .addr, .fifo_sel, .data_in, .data_out);
  always @(posedge mclk) begin
    if (wr_valid === 1'b1) begin
      wr_cnt++;
      last_word = wr_word;
      last_waddr = wr_addr;
    end
    if (rd_req === 1'b1) begin
      rd_cnt++;
      last_raddr = rd_addr;
    end
    if (data_oe === 1'b1) begin
      oe_cnt++;
    end
  end
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // ==========================================================
  // helpers
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic rd(input logic fs, input logic [6:0] a);
    host.acc(1'b1, 1'b1, 1'b0, fs, a, 16'h0000, q);
  endtask
  task automatic wr(input logic fs, input logic [6:0] a,
      input logic [15:0] d);
    host.acc(1'b1, 1'b0, 1'b1, fs, a, d, q);
  endtask
  task automatic do_reset(input logic s);
    speed_strap <= s;
    srst <= 1'b1;
    tick(4);
    srst <= 1'b0;
    tick(3);
    speed_strap <= ~s;
    tick(2);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d errors %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    tick(5000);
    failures++;
    print_verdict();
  end
  // ==========================================================
  // scenarios
  initial begin
    srst = 1'b1;
    speed_strap = 1'b0;
    big_endian = 1'b0;
    sleep_req = 1'b0;
    irq_src = 8'h00;
    irq_enable = 8'h01;
    irq_polarity_high = 1'b1;
    irq_open_drain = 1'b0;
    irq_holdoff = 8'h00;
    rd_word = 32'ha1b2c3d4;
    crossover_auto_enable = 1'b0;
    cable_reversed = 1'b0;
    manual_reverse = 1'b0;
    for (int s = 0; s < 2; s++) begin
      do_reset(s[0]);
      `CHK(link_speed_100, s[0])
      `CHK(link_autoneg, s[0])
      `CHK(link_duplex_full, 1'b0)
    end
    wr(1'b0, 7'h20, 16'h1111);
    wr(1'b0, 7'h21, 16'h2222);
    `CHK(wr_cnt, 0)
    rd(1'b0, 7'h20);
    `CHK(q, 16'hc3d4)
    `CHK(last_raddr, 7'h20)
    rd(1'b0, 7'h21);
    `CHK(q, 16'ha1b2)
    `CHK(write_enabled, 1'b1)
    big_endian <= 1'b1;
    rd(1'b0, 7'h20);
    `CHK(q, 16'hd4c3)
    wr(1'b0, 7'h22, 16'h1234);
    wr(1'b0, 7'h23, 16'h5678);
    `CHK(last_word, 32'h78563412)
    big_endian <= 1'b0;
    wr(1'b0, 7'h22, 16'h1234);
    wr(1'b0, 7'h23, 16'h5678);
    `CHK(last_word, 32'h56781234)
    `CHK(last_waddr, 7'h22)
    `CHK(wr_cnt, 2)
    host.acc(1'b0, 1'b0, 1'b1, 1'b0, 7'h24, 16'h0001, q);
    host.acc(1'b0, 1'b0, 1'b1, 1'b0, 7'h25, 16'h0002, q);
    host.acc(1'b0, 1'b1, 1'b0, 1'b0, 7'h24, 16'h0000, q);
    `CHK(wr_cnt, 2)
    `CHK(rd_cnt, 2)
    `CHK(oe_cnt, 12)
    host.acc(1'b1, 1'b1, 1'b1, 1'b0, 7'h24, 16'h0001, q);
    host.acc(1'b1, 1'b1, 1'b1, 1'b0, 7'h25, 16'h0002, q);
    `CHK(wr_cnt, 2)
    `CHK(rd_cnt, 2)
    `CHK(oe_cnt, 12)
    rd(1'b1, 7'h7c);
    `CHK(last_raddr, shp_pkg::ADDR_RX_FIFO)
    wr(1'b1, 7'h7a, 16'hbeef);
    wr(1'b1, 7'h7b, 16'hcafe);
    `CHK(last_waddr, shp_pkg::ADDR_TX_FIFO)
    `CHK(last_word, 32'hcafebeef)
    sleep_req <= 1'b1;
    tick(3);
    `CHK(asleep, 1'b1)
    sleep_req <= 1'b0;
    wr(1'b0, 7'h20, 16'h0101);
    wr(1'b0, 7'h21, 16'h0202);
    `CHK(asleep, 1'b0)
    `CHK(wr_cnt, 3)
    rd(1'b0, 7'h20);
    wr(1'b0, 7'h20, 16'h0303);
    wr(1'b0, 7'h21, 16'h0404);
    `CHK(wr_cnt, 4)
    `CHK(last_word, 32'h04040303)
    for (int i = 0; i < 8; i++) begin
      {crossover_auto_enable, cable_reversed, manual_reverse} <= i[2:0];
      tick(3);
      `CHK(auto_crossover_on, i[2])
      `CHK(pairs_swapped, (i[2] & i[1]) | i[0])
    end
    irq_src <= 8'h01;
    tick(4);
    `CHK(irq_out, 1'b1)
    `CHK(irq_oe, 1'b1)
    irq_enable <= 8'h00;
    tick(4);
    `CHK(irq_out, 1'b0)
    irq_enable <= 8'h01;
    irq_polarity_high <= 1'b0;
    irq_open_drain <= 1'b1;
    tick(4);
    `CHK(irq_out, 1'b0)
    `CHK(irq_oe, 1'b1)
    irq_src <= 8'h00;
    tick(4);
    `CHK(irq_oe, 1'b0)
    irq_polarity_high <= 1'b1;
    irq_open_drain <= 1'b0;
    irq_holdoff <= 8'h10;
    irq_src <= 8'h01;
    tick(4);
    irq_src <= 8'h00;
    tick(2);
    irq_src <= 8'h01;
    tick(4);
    `CHK(irq_out, 1'b0)
    tick(20);
    `CHK(irq_out, 1'b1)
    print_verdict();
  end
endmodule

// >>> rtl/shp_host_port.sv
// sram-style host port: strobe decode, 16/32 pairing, fifo select,
// wake on write, straps, crossover and interrupt output
// assumes host pins are synchronous to mclk and held per access
`timescale 1ns/1ps
module shp_host_port #(
  parameter int SRC_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // host bus
  input wire logic chip_select_n,
  input wire logic read_strobe_n,
  input wire logic write_strobe_n,
  input wire logic [6:0] addr,
  input wire logic fifo_sel,
  input wire logic [15:0] data_in,
  output logic [15:0] data_out,
  output logic data_oe,
  // configuration
  input wire logic big_endian,
  input wire logic [SRC_W-1:0] irq_src,
  input wire logic [SRC_W-1:0] irq_enable,
  input wire logic irq_polarity_high,
  input wire logic irq_open_drain,
  input wire logic [shp_pkg::HOLDOFF_W-1:0] irq_holdoff,
  input wire logic sleep_req,
  // internal 32-bit paths
  output logic [31:0] wr_word,
  output logic [6:0] wr_addr,
  output logic wr_valid,
  output logic [6:0] rd_addr,
  output logic rd_req,
  input wire logic [31:0] rd_word,
  // power and link
  output logic asleep,
  output logic write_enabled,
  input wire logic speed_strap,
  input wire logic crossover_auto_enable,
  input wire logic cable_reversed,
  input wire logic manual_reverse,
  output logic link_speed_100,
  output logic link_duplex_full,
  output logic link_autoneg,
  output logic auto_crossover_on,
  output logic pairs_swapped,
  // interrupt pin
  output logic irq_out,
  output logic irq_oe
);
  shp_pkg::shp_acc_e acc, acc_q;
  logic [6:0] eff_addr;
  logic half_sel;
  logic [15:0] low_half;
  logic srst_q;
  logic read_seen;
  logic [31:0] rd_hold;

  function automatic logic [15:0] swap16(input logic [15:0] v,
                                         input logic be);
    swap16 = be ? {v[7:0], v[15:8]} : v;
  endfunction

  // ==========================================================
  // access decode: chip select qualifies one low strobe
  always_comb begin
    if (chip_select_n)
      acc = shp_pkg::SHP_IDLE;
    else if (!read_strobe_n && write_strobe_n)
      acc = shp_pkg::SHP_READ;
    else if (!write_strobe_n && read_strobe_n)
      acc = shp_pkg::SHP_WRITE;
    else
      acc = shp_pkg::SHP_IDLE;
  end

  // fifo select folds the address onto the data fifo ports
  always_comb begin
    if (fifo_sel)
      eff_addr = addr[shp_pkg::FIFO_SEL_TX_BIT] ? shp_pkg::ADDR_TX_FIFO
                 : shp_pkg::ADDR_RX_FIFO;
    else
      eff_addr = addr;
  end
  // a[1] is addr[0]: picks the half of the 32-bit word
  assign half_sel = addr[0];

  always_ff @(posedge mclk) begin
    if (srst)
      acc_q <= shp_pkg::SHP_IDLE;
    else
      acc_q <= acc;
  end

  // ==========================================================
  // power: sleep on request, a qualified write wakes
  always_ff @(posedge mclk) begin
    if (srst)
      asleep <= 1'b0;
    else if (acc == shp_pkg::SHP_WRITE)
      asleep <= 1'b0;
    else if (sleep_req)
      asleep <= 1'b1;
  end

  // writes take effect only after a first read since reset or wake
  always_ff @(posedge mclk) begin
    if (srst)
      read_seen <= 1'b0;
    else if (asleep)
      read_seen <= 1'b0;
    else if (acc == shp_pkg::SHP_READ && acc_q != shp_pkg::SHP_READ)
      read_seen <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (srst)
      write_enabled <= 1'b0;
    else
      write_enabled <= read_seen;
  end

  // ==========================================================
  // write path: low half stored, high half completes the word
  always_ff @(posedge mclk) begin
    if (srst) begin
      low_half <= shp_pkg::RDATA_RST;
      wr_word <= '0;
      wr_addr <= '0;
      wr_valid <= 1'b0;
    end else begin
      wr_valid <= 1'b0;
      if (acc == shp_pkg::SHP_WRITE && acc_q != shp_pkg::SHP_WRITE
          && read_seen && !asleep) begin
        if (!half_sel) begin
          low_half <= swap16(data_in, big_endian);
        end else begin
          wr_word <= {swap16(data_in, big_endian), low_half};
          wr_addr <= {eff_addr[6:1], 1'b0};
          wr_valid <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // read path: low half fetches the word, high half reuses it
  always_ff @(posedge mclk) begin
    if (srst) begin
      rd_req <= 1'b0;
      rd_addr <= '0;
    end else begin
      rd_req <= acc == shp_pkg::SHP_READ && acc_q != shp_pkg::SHP_READ
                && !half_sel;
      rd_addr <= {eff_addr[6:1], 1'b0};
    end
  end
  always_ff @(posedge mclk) begin
    if (srst)
      rd_hold <= '0;
    else if (rd_req)
      rd_hold <= rd_word;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      data_out <= shp_pkg::RDATA_RST;
      data_oe <= 1'b0;
    end else begin
      data_oe <= acc == shp_pkg::SHP_READ;
      if (rd_req && !half_sel)
        data_out <= swap16(rd_word[15:0], big_endian);
      else if (acc == shp_pkg::SHP_READ && half_sel)
        data_out <= swap16(rd_hold[31:16], big_endian);
    end
  end

  // ==========================================================
  // straps caught on the first edge after reset release
  always_ff @(posedge mclk) begin
    if (srst)
      srst_q <= 1'b1;
    else
      srst_q <= 1'b0;
  end
  always_ff @(posedge mclk) begin
    if (srst) begin
      link_speed_100 <= shp_pkg::SPEED_10;
      link_autoneg <= 1'b0;
      link_duplex_full <= shp_pkg::DUPLEX_HALF;
    end else if (srst_q) begin
      link_speed_100 <= speed_strap ? shp_pkg::SPEED_100
                        : shp_pkg::SPEED_10;
      link_autoneg <= speed_strap;
      link_duplex_full <= shp_pkg::DUPLEX_HALF;
    end
  end

  // ==========================================================
  // crossover control
  always_ff @(posedge mclk) begin
    if (srst) begin
      auto_crossover_on <= 1'b0;
      pairs_swapped <= 1'b0;
    end else begin
      auto_crossover_on <= crossover_auto_enable;
      pairs_swapped <= manual_reverse
                       || (crossover_auto_enable && cable_reversed);
    end
  end

  // ==========================================================
  // interrupt
  shp_irq_ctl #(.SRC_W(SRC_W)) u_irq (
    .mclk(mclk),
    .srst(srst),
    .src(irq_src),
    .src_enable(irq_enable),
    .polarity_high(irq_polarity_high),
    .open_drain(irq_open_drain),
    .holdoff(irq_holdoff),
    .irq_out(irq_out),
    .irq_oe(irq_oe)
  );

  // ==========================================================
  // checks
  a_cs_gates_oe: assert property (
    @(posedge mclk) disable iff (srst)
    chip_select_n |=> !data_oe)
    else $error("data driven without chip select");
  a_both_strobes_idle: assert property (
    @(posedge mclk) disable iff (srst)
    !read_strobe_n && !write_strobe_n |=> !data_oe && !wr_valid)
    else $error("both strobes treated as access");
  a_read_drives: assert property (
    @(posedge mclk) disable iff (srst)
    !chip_select_n && !read_strobe_n && write_strobe_n |=> data_oe)
    else $error("read not answered");
  a_write_wakes: assert property (
    @(posedge mclk) disable iff (srst)
    asleep && !chip_select_n && !write_strobe_n && read_strobe_n
    |=> !asleep)
    else $error("write did not wake");
  a_write_needs_read: assert property (
    @(posedge mclk) disable iff (srst)
    wr_valid |-> $past(read_seen))
    else $error("write accepted before first read");
  a_fifo_sel_map: assert property (
    @(posedge mclk) disable iff (srst)
    fifo_sel && !chip_select_n && !read_strobe_n && write_strobe_n
    |=> rd_addr[6:shp_pkg::FIFO_SEL_LSB] == '0
        || rd_addr == shp_pkg::ADDR_TX_FIFO)
    else $error("fifo select did not steer to a data fifo");
  a_strap_speed: assert property (
    @(posedge mclk) disable iff (srst)
    srst_q |=> link_speed_100 == $past(speed_strap)
               && link_autoneg == $past(speed_strap))
    else $error("strap not latched at release");
  a_swap_auto: assert property (
    @(posedge mclk) disable iff (srst)
    !manual_reverse && !crossover_auto_enable |=> !pairs_swapped)
    else $error("pairs swapped with crossover disabled");
  a_pair_word: assert property (
    @(posedge mclk) disable iff (srst)
    wr_valid |-> wr_word[15:0] == low_half)
    else $error("write word halves mismatched");
  a_rd_pulse: assert property (
    @(posedge mclk) disable iff (srst)
    rd_req |=> !rd_req)
    else $error("read fetch held for two cycles");
  a_wr_pulse: assert property (
    @(posedge mclk) disable iff (srst)
    wr_valid |=> !wr_valid)
    else $error("write word handed over twice");
  a_wr_even: assert property (
    @(posedge mclk) disable iff (srst)
    wr_valid |-> !wr_addr[0])
    else $error("write word address not even");
  a_sleep_drops: assert property (
    @(posedge mclk) disable iff (srst)
    asleep |=> !wr_valid && !read_seen)
    else $error("write taken while asleep");
  a_oe_qualified: assert property (
    @(posedge mclk) disable iff (srst)
    data_oe |-> $past(!chip_select_n && !read_strobe_n && write_strobe_n))
    else $error("data driven without a qualified read");
  a_wr_qualified: assert property (
    @(posedge mclk) disable iff (srst)
    wr_valid |-> $past(!chip_select_n && !write_strobe_n && read_strobe_n))
    else $error("write word without a qualified write");
  a_strap_stable: assert property (
    @(posedge mclk) disable iff (srst)
    !srst_q |=> $stable(link_speed_100) && $stable(link_autoneg))
    else $error("link defaults moved after release");
  a_xover_follow: assert property (
    @(posedge mclk) disable iff (srst)
    1'b1 |=> auto_crossover_on == $past(crossover_auto_enable))
    else $error("crossover enable not followed");
  a_manual_swap: assert property (
    @(posedge mclk) disable iff (srst)
    manual_reverse |=> pairs_swapped)
    else $error("manual reversal did not swap pairs");

  c_read: cover property (@(posedge mclk) rd_req);
  c_write: cover property (@(posedge mclk) wr_valid);
  c_wake: cover property (@(posedge mclk) $fell(asleep));
  c_swap: cover property (@(posedge mclk) pairs_swapped);
  c_fifo_tx: cover property (@(posedge mclk)
    wr_valid && wr_addr == shp_pkg::ADDR_TX_FIFO);
endmodule

// >>> rtl/shp_irq_ctl.sv
// interrupt output stage with hold-off timer
// assumes sources are level inputs on mclk
`timescale 1ns/1ps
module shp_irq_ctl #(
  parameter int SRC_W = 8
) (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // control
  input wire logic [SRC_W-1:0] src,
  input wire logic [SRC_W-1:0] src_enable,
  input wire logic polarity_high,
  input wire logic open_drain,
  input wire logic [shp_pkg::HOLDOFF_W-1:0] holdoff,
  // pin
  output logic irq_out,
  output logic irq_oe
);
  logic pending;
  logic [shp_pkg::HOLDOFF_W-1:0] hold_cnt;
  logic asserted;
  assign pending = |(src & src_enable);

  // ==========================================================
  // hold-off: after a deassertion wait holdoff cycles
  always_ff @(posedge mclk) begin
    if (srst) begin
      asserted <= 1'b0;
      hold_cnt <= shp_pkg::HOLDOFF_RST;
    end else if (asserted) begin
      if (!pending) begin
        asserted <= 1'b0;
        hold_cnt <= holdoff;
      end
    end else if (hold_cnt != '0) begin
      hold_cnt <= hold_cnt - 1'b1;
    end else if (pending) begin
      asserted <= 1'b1;
    end
  end

  // ==========================================================
  // pin drive: open drain only pulls to the active level
  always_ff @(posedge mclk) begin
    if (srst) begin
      irq_out <= 1'b0;
      irq_oe <= 1'b0;
    end else begin
      irq_out <= asserted ~^ polarity_high;
      irq_oe <= open_drain ? asserted : 1'b1;
    end
  end

  a_irq_holdoff: assert property (
    @(posedge mclk) disable iff (srst)
    $fell(asserted) && holdoff != '0 |=> !asserted)
    else $error("interrupt reasserted inside hold-off");
  a_irq_polar: assert property (
    @(posedge mclk) disable iff (srst)
    !open_drain |=> irq_out == ($past(asserted) ~^ $past(polarity_high)))
    else $error("interrupt level does not follow polarity");
endmodule

// >>> rtl/shp_pkg.sv
// constants and types for the sram-style host port
// assumes a single 250 mhz clock domain and synchronous inputs
//
// Operation
// - the host reaches registers and both data fifos by programmed io only.
// - a 7-bit word address on bits 7..1 selects registers or data fifos.
// - 16-bit host transfers are paired into 32-bit internal words.
// - the byte order on the host bus is big or little endian by choice.
// - only a low read strobe marks a read request.
// - only a low write strobe marks a write request.
// - chip select must be low to qualify any strobe.
// - a qualified write wakes the device from its reduced power state.
// - with fifo select high every access goes to a data fifo, a[7:3] unused.
// - the link-rate strap is caught at reset release as the default.
// - strap 0 gives 10 mbps half no autoneg, 1 gives 100 half autoneg.
// - auto crossover is on only while its enable input is high.
// - a reversed cable with auto crossover enabled, or manual reversal, swaps tx and rx pair roles.
// - one interrupt output with software sources, polarity and type.
// - a programmable interval holds off reassertion of the interrupt.
package shp_pkg;
  // ==========================================================
  // address map (word addresses)
  localparam logic [6:0] ADDR_RX_FIFO = 7'h00;
  localparam logic [6:0] ADDR_TX_FIFO = 7'h10;
  localparam logic [6:0] ADDR_CSR_BASE = 7'h20;
  localparam int FIFO_SEL_LSB = 3;
  // a[2] picks the fifo: a[7:3] are ignored in fifo mode
  localparam int FIFO_SEL_TX_BIT = 1;
  // ==========================================================
  // link defaults
  localparam logic SPEED_10 = 1'b0;
  localparam logic SPEED_100 = 1'b1;
  localparam logic DUPLEX_HALF = 1'b0;
  // ==========================================================
  // interrupt hold-off
  localparam int HOLDOFF_W = 8;
  localparam logic [7:0] HOLDOFF_RST = 8'h00;
  localparam logic [15:0] RDATA_RST = 16'h0000;
  typedef enum logic [1:0] {
    SHP_IDLE,
    SHP_READ,
    SHP_WRITE
  } shp_acc_e;
endpackage
